//--- cca_pkg.sv
// constants and types for the clear channel assessment engine
// assumes a 50 MHz system clock and 32-bit avalon words holding 8-bit data
package cca_pkg;

  // ----------------------------------------
  // register indices, byte address is 4x index
  // ----------------------------------------
  localparam logic [6:0] IDX_CONV_CLK_SEL = 7'h08;
  localparam logic [6:0] IDX_IGNORE_LEVEL = 7'h12;
  localparam logic [6:0] IDX_THRESHOLD = 7'h13;
  localparam logic [6:0] IDX_CONTROL = 7'h15;
  localparam logic [6:0] IDX_ENERGY_RESULT = 7'h16;
  localparam logic [6:0] IDX_IDLE_HOLD_LOW = 7'h17;
  localparam logic [6:0] IDX_IDLE_HOLD_HIGH = 7'h18;
  localparam logic [6:0] IDX_AVG_CONTROL = 7'h1b;
  localparam logic [6:0] IDX_PACKET_MODE = 7'h45;
  localparam logic [6:0] IDX_AUTO_ACK = 7'h55;
  localparam logic [6:0] IDX_ADDR_FILTER = 7'h60;
  localparam logic [6:0] IDX_IRQ_STATUS = 7'h70;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_CONV_SEL = 4;
  localparam int BIT_AUTO_EN = 7;
  localparam int BIT_LOOP_END = 6;
  localparam int BIT_LOOP_BEGIN = 5;
  localparam int BIT_ENABLE = 4;
  localparam int BIT_IDLE_EN = 3;
  localparam int BIT_DONE = 2;
  localparam int BIT_ACK_EN = 4;
  localparam int BIT_MISMATCH_IDLE = 0;
  localparam int BIT_IRQ = 0;

  // ----------------------------------------
  // reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RES_IDLE = 2'h0;
  localparam logic [1:0] RES_BUSY = 2'h1;
  localparam logic [1:0] RES_PENDING = 2'h3;
  localparam logic [2:0] AVG_CODE_MAX = 3'h3;
  localparam int SETTLE_CONV = 2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int CONV_SLOW_NS = 17800;
  localparam int CONV_FAST_NS = 16000;
  localparam int CONV_SLOW_CYC = CONV_SLOW_NS * CLK_MHZ / 1000;
  localparam int CONV_FAST_CYC = CONV_FAST_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_CONT = 2'b01,
    MODE_IDLE = 2'b10
  } cca_mode_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_SETTLE = 2'b01,
    ST_GATHER = 2'b10,
    ST_EVAL = 2'b11
  } cca_state_t;

  typedef struct packed {
    logic autoEn;
    logic loopBegin;
    logic enable;
    logic idleEn;
  } cca_ctrl_t;

endpackage

//--- cca_engine.sv
// clear channel assessment engine with avalon-mm register slave
// assumes energy samples come from same-clock receive logic
// What this block does
// - receive-on with enable set, idle and loop bits clear, runs normal mode
// - receive-on with enable and loop bit set runs continuous mode
// - receive-on with enable and idle bit set runs idle-detection mode
// - auto-ack with auto-assess bit runs idle detection before sending the ack
// - address mismatch with filter on and idle-check bit runs idle detection
// - average above threshold gives busy, result field 01
// - idle, result 00, only after average stays below for the hold count
// - normal mode decision sets done flag and raises completion interrupt
// - normal mode decision clears the enable bit by hardware
// - clearing the completion interrupt resets the result field to 00
// - no idle decision while a strong sample is inside the window
// - strong exclusion: above gives busy and ends normal mode only, below shows 11 and runs on
// - idle takes (average count plus hold) conversions plus two settling
// - busy takes average count conversions plus two settling
// - converter select picks 17.8 us or 16 us conversion period
// - after start, input counts as silent until the filter settles
// - continuous mode runs on until host writes loop end
// - continuous mode refreshes the result on every new energy value
// - continuous mode never sets done nor raises the interrupt
`timescale 1ns/1ps
`default_nettype none

module cca_engine #(
  parameter int WIN_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxOnCmd,
  input wire logic ackRequest,
  input wire logic addrMismatch,
  input wire logic [7:0] energySample,
  output logic ackGo,
  output logic assessIrq,
  output logic assessBusy
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] convSel_reg;
  logic [7:0] ignoreLevel_reg;
  logic [7:0] threshold_reg;
  cca_pkg::cca_ctrl_t ctrl_reg;
  logic done_reg;
  logic [1:0] result_reg;
  logic [7:0] avgOut_reg;
  logic [7:0] holdLow_reg;
  logic [1:0] holdHigh_reg;
  logic [7:0] avgCtrl_reg;
  logic [7:0] packetMode_reg;
  logic [7:0] autoAck_reg;
  logic [7:0] addrFilter_reg;
  logic irq_reg;
  logic waitReq_reg;
  logic [31:0] rdata_reg;
  logic ackGo_reg;
  logic busy_reg;

  cca_pkg::cca_state_t state_reg;
  cca_pkg::cca_mode_t mode_reg;
  logic byRegister_reg;
  logic byAck_reg;
  logic [9:0] convCnt_reg;
  logic [1:0] settleCnt_reg;
  logic [3:0] gathered_reg;
  logic [9:0] idleCnt_reg;
  logic [7:0] win_reg [0:WIN_DEPTH-1];
  logic [WIN_DEPTH-1:0] strong_reg;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [6:0] idx;
  logic busReq;
  logic accept;
  logic wrHit;
  logic wrLane0;
  assign idx = avs_address[8:2];
  assign busReq = avs_read | avs_write;
  // a request is finished at the edge where waitrequest is seen low
  assign accept = busReq & ~waitReq_reg;
  assign wrLane0 = avs_write & accept & avs_byteenable[0];
  assign wrHit = wrLane0 & (avs_address[1:0] == 2'h0);

  logic wrCtrl;
  logic loopEndCmd;
  logic irqClear;
  assign wrCtrl = wrHit & (idx == cca_pkg::IDX_CONTROL);
  assign loopEndCmd = wrCtrl & avs_writedata[cca_pkg::BIT_LOOP_END];
  assign irqClear = wrHit & (idx == cca_pkg::IDX_IRQ_STATUS)
    & avs_writedata[cca_pkg::BIT_IRQ];

  // ----------------------------------------
  // conversion divider
  // ----------------------------------------
  logic [9:0] convLast;
  logic convTick;
  always_comb
  begin
    if (convSel_reg[cca_pkg::BIT_CONV_SEL])
      convLast = 10'(cca_pkg::CONV_FAST_CYC - 1);
    else
      convLast = 10'(cca_pkg::CONV_SLOW_CYC - 1);
  end
  assign convTick = (state_reg != cca_pkg::ST_OFF)
    && (convCnt_reg == convLast);

  // ----------------------------------------
  // window average and strong-sample check
  // ----------------------------------------
  logic [2:0] avgCode;
  logic [3:0] needCnt;
  logic [10:0] winSum;
  logic [7:0] winAvg;
  logic strongInWin;
  logic [9:0] holdTarget;
  // window is held in flops, so averaging is capped at eight samples
  assign avgCode = (avgCtrl_reg[2:0] > cca_pkg::AVG_CODE_MAX) ?
    cca_pkg::AVG_CODE_MAX : avgCtrl_reg[2:0];
  assign needCnt = 4'(4'h1 << avgCode);
  assign holdTarget = {holdHigh_reg, holdLow_reg};

  always_comb
  begin
    winSum = 11'h000;
    strongInWin = 1'b0;
    for (int i = 0; i < WIN_DEPTH; i++)
    begin
      if (i < int'(needCnt))
      begin
        winSum = winSum + 11'(win_reg[i]);
        strongInWin = strongInWin | strong_reg[i];
      end
    end
    winAvg = 8'(winSum >> avgCode);
  end

  // ----------------------------------------
  // start decode
  // ----------------------------------------
  logic regStart;
  logic ackStart;
  logic mismatchStart;
  logic anyStart;
  logic modeLegal;
  assign modeLegal = ~(ctrl_reg.idleEn & ctrl_reg.loopBegin);
  assign regStart = rxOnCmd & ctrl_reg.enable & modeLegal;
  assign ackStart = ackRequest & autoAck_reg[cca_pkg::BIT_ACK_EN]
    & ctrl_reg.autoEn;
  assign mismatchStart = addrMismatch & (|addrFilter_reg[4:0])
    & packetMode_reg[cca_pkg::BIT_MISMATCH_IDLE];
  assign anyStart = (state_reg == cca_pkg::ST_OFF)
    & (regStart | ackStart | mismatchStart);

  // ----------------------------------------
  // decision
  // ----------------------------------------
  logic evalNow;
  logic aboveThr;
  logic idleReached;
  logic finishNow;
  assign evalNow = state_reg == cca_pkg::ST_EVAL;
  assign aboveThr = winAvg > threshold_reg;
  assign idleReached = ~aboveThr & ~strongInWin
    & (idleCnt_reg >= holdTarget);
  always_comb
  begin
    finishNow = 1'b0;
    if (evalNow)
    begin
      case (mode_reg)
        cca_pkg::MODE_NORMAL: finishNow = aboveThr | idleReached;
        cca_pkg::MODE_IDLE: finishNow = idleReached;
        default: finishNow = 1'b0;
      endcase
    end
  end
  logic stopLoop;
  assign stopLoop = loopEndCmd & (mode_reg == cca_pkg::MODE_CONT)
    & (state_reg != cca_pkg::ST_OFF);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= cca_pkg::ST_OFF;
      mode_reg <= cca_pkg::MODE_NORMAL;
      byRegister_reg <= 1'b0;
      byAck_reg <= 1'b0;
      settleCnt_reg <= 2'h0;
      gathered_reg <= 4'h0;
    end
    else
    begin
      case (state_reg)
        cca_pkg::ST_OFF:
        begin
          if (anyStart)
          begin
            state_reg <= cca_pkg::ST_SETTLE;
            settleCnt_reg <= 2'h0;
            gathered_reg <= 4'h0;
            byRegister_reg <= regStart;
            byAck_reg <= ~regStart & ackStart;
            if (!regStart)
              mode_reg <= cca_pkg::MODE_IDLE;
            else if (ctrl_reg.idleEn)
              mode_reg <= cca_pkg::MODE_IDLE;
            else if (ctrl_reg.loopBegin)
              mode_reg <= cca_pkg::MODE_CONT;
            else
              mode_reg <= cca_pkg::MODE_NORMAL;
          end
        end
        cca_pkg::ST_SETTLE:
        begin
          if (convTick)
          begin
            settleCnt_reg <= settleCnt_reg + 2'h1;
            if (settleCnt_reg == 2'(cca_pkg::SETTLE_CONV - 1))
              state_reg <= cca_pkg::ST_GATHER;
          end
        end
        cca_pkg::ST_GATHER:
        begin
          if (convTick)
          begin
            if (gathered_reg < needCnt)
              gathered_reg <= gathered_reg + 4'h1;
            if (gathered_reg + 4'h1 >= needCnt)
              state_reg <= cca_pkg::ST_EVAL;
          end
        end
        cca_pkg::ST_EVAL:
        begin
          if (finishNow)
            state_reg <= cca_pkg::ST_OFF;
          else
            state_reg <= cca_pkg::ST_GATHER;
        end
        default: state_reg <= cca_pkg::ST_OFF;
      endcase
      if (stopLoop)
        state_reg <= cca_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      convCnt_reg <= 10'h000;
    else if (state_reg == cca_pkg::ST_OFF || convTick)
      convCnt_reg <= 10'h000;
    else
      convCnt_reg <= convCnt_reg + 10'h001;
  end

  // window is cleared at start so settling reads as silence
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < WIN_DEPTH; i++)
        win_reg[i] <= cca_pkg::RST_BYTE;
      strong_reg <= '0;
    end
    else if (anyStart)
    begin
      for (int i = 0; i < WIN_DEPTH; i++)
        win_reg[i] <= cca_pkg::RST_BYTE;
      strong_reg <= '0;
    end
    else if (convTick && state_reg == cca_pkg::ST_GATHER)
    begin
      win_reg[0] <= energySample;
      for (int i = 1; i < WIN_DEPTH; i++)
        win_reg[i] <= win_reg[i-1];
      strong_reg <= {strong_reg[WIN_DEPTH-2:0],
        energySample > ignoreLevel_reg};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      idleCnt_reg <= 10'h000;
    else if (anyStart)
      idleCnt_reg <= 10'h000;
    else if (evalNow)
    begin
      // strong samples and busy restart the hold count
      if (aboveThr || strongInWin)
        idleCnt_reg <= 10'h000;
      else if (idleCnt_reg < holdTarget)
        idleCnt_reg <= idleCnt_reg + 10'h001;
    end
  end

  // ----------------------------------------
  // result, done and interrupt
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      result_reg <= cca_pkg::RES_IDLE;
    else if (evalNow)
    begin
      if (aboveThr)
        result_reg <= cca_pkg::RES_BUSY;
      else if (strongInWin)
        result_reg <= cca_pkg::RES_PENDING;
      else if (idleReached)
        result_reg <= cca_pkg::RES_IDLE;
    end
    else if (irqClear)
      result_reg <= cca_pkg::RES_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      avgOut_reg <= cca_pkg::RST_BYTE;
    else if (evalNow)
      avgOut_reg <= winAvg;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else if (finishNow)
    begin
      done_reg <= 1'b1;
      irq_reg <= 1'b1;
    end
    else if (irqClear)
    begin
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ackGo_reg <= 1'b0;
    else
      ackGo_reg <= finishNow & byAck_reg;
  end

  // registered busy trails the state by one cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      busy_reg <= 1'b0;
    else
      busy_reg <= state_reg != cca_pkg::ST_OFF;
  end

  // ----------------------------------------
  // control register, hardware clear wins
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= '0;
    else
    begin
      if (wrCtrl)
      begin
        ctrl_reg.autoEn <= avs_writedata[cca_pkg::BIT_AUTO_EN];
        ctrl_reg.loopBegin <= avs_writedata[cca_pkg::BIT_LOOP_BEGIN];
        ctrl_reg.enable <= avs_writedata[cca_pkg::BIT_ENABLE];
        ctrl_reg.idleEn <= avs_writedata[cca_pkg::BIT_IDLE_EN];
      end
      if (finishNow && byRegister_reg)
      begin
        ctrl_reg.enable <= 1'b0;
        if (mode_reg == cca_pkg::MODE_IDLE)
          ctrl_reg.idleEn <= 1'b0;
      end
      if (stopLoop && byRegister_reg)
      begin
        ctrl_reg.enable <= 1'b0;
        ctrl_reg.loopBegin <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // plain setting registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convSel_reg <= cca_pkg::RST_BYTE;
      ignoreLevel_reg <= cca_pkg::RST_BYTE;
      threshold_reg <= cca_pkg::RST_BYTE;
      holdLow_reg <= cca_pkg::RST_BYTE;
      holdHigh_reg <= 2'h0;
      avgCtrl_reg <= cca_pkg::RST_BYTE;
      packetMode_reg <= cca_pkg::RST_BYTE;
      autoAck_reg <= cca_pkg::RST_BYTE;
      addrFilter_reg <= cca_pkg::RST_BYTE;
    end
    else if (wrHit)
    begin
      case (idx)
        cca_pkg::IDX_CONV_CLK_SEL: convSel_reg <= avs_writedata[7:0];
        cca_pkg::IDX_IGNORE_LEVEL: ignoreLevel_reg <= avs_writedata[7:0];
        cca_pkg::IDX_THRESHOLD: threshold_reg <= avs_writedata[7:0];
        cca_pkg::IDX_IDLE_HOLD_LOW: holdLow_reg <= avs_writedata[7:0];
        cca_pkg::IDX_IDLE_HOLD_HIGH: holdHigh_reg <= avs_writedata[1:0];
        cca_pkg::IDX_AVG_CONTROL: avgCtrl_reg <= avs_writedata[7:0];
        cca_pkg::IDX_PACKET_MODE: packetMode_reg <= avs_writedata[7:0];
        cca_pkg::IDX_AUTO_ACK: autoAck_reg <= avs_writedata[7:0];
        cca_pkg::IDX_ADDR_FILTER: addrFilter_reg <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // bus answer: one wait cycle, then data
  // ----------------------------------------
  logic [7:0] rdByte;
  always_comb
  begin
    case (idx)
      cca_pkg::IDX_CONV_CLK_SEL: rdByte = convSel_reg;
      cca_pkg::IDX_IGNORE_LEVEL: rdByte = ignoreLevel_reg;
      cca_pkg::IDX_THRESHOLD: rdByte = threshold_reg;
      cca_pkg::IDX_CONTROL: rdByte = {ctrl_reg.autoEn, 1'b0,
        ctrl_reg.loopBegin, ctrl_reg.enable, ctrl_reg.idleEn,
        done_reg, result_reg};
      cca_pkg::IDX_ENERGY_RESULT: rdByte = avgOut_reg;
      cca_pkg::IDX_IDLE_HOLD_LOW: rdByte = holdLow_reg;
      cca_pkg::IDX_IDLE_HOLD_HIGH: rdByte = {6'h00, holdHigh_reg};
      cca_pkg::IDX_AVG_CONTROL: rdByte = avgCtrl_reg;
      cca_pkg::IDX_PACKET_MODE: rdByte = packetMode_reg;
      cca_pkg::IDX_AUTO_ACK: rdByte = autoAck_reg;
      cca_pkg::IDX_ADDR_FILTER: rdByte = addrFilter_reg;
      cca_pkg::IDX_IRQ_STATUS: rdByte = {7'h00, irq_reg};
      default: rdByte = 8'h00;
    endcase
    if (avs_address[1:0] != 2'h0)
      rdByte = 8'h00;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitReq_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      waitReq_reg <= ~(busReq & waitReq_reg);
      if (avs_read && waitReq_reg)
        rdata_reg <= {24'h00_0000, rdByte};
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = waitReq_reg;
  assign ackGo = ackGo_reg;
  assign assessIrq = irq_reg;
  assign assessBusy = busy_reg;

endmodule

`default_nettype wire

//--- cca_engine_checker.sv
// port checker for the assessment engine
// assumes a bind from the bench top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module cca_engine_checker #(
  parameter int WIN_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ackGo,
  input wire logic assessIrq,
  input wire logic assessBusy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  AST_REST_HIGH: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  AST_RDATA_UPPER: assert property (!avs_waitrequest
    |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  // ----------------------------------------
  // assessment events
  // ----------------------------------------
  AST_IRQ_CAUSE: assert property ($rose(assessIrq)
    |-> $past(assessBusy))
    else $error("interrupt without a running assessment");
  AST_IRQ_HOLD: assert property (assessIrq
    && !(avs_write && !avs_waitrequest) |=> assessIrq)
    else $error("interrupt dropped without host clear");
  AST_ACKGO_PULSE: assert property (ackGo |=> !ackGo)
    else $error("ack release longer than one cycle");
  AST_ACKGO_CAUSE: assert property (ackGo |-> $past(assessBusy))
    else $error("ack released without assessment");
  AST_BUSY_MIN: assert property ($rose(assessBusy) |=> assessBusy[*8])
    else $error("assessment ended before settling");
endmodule
`default_nettype wire

//--- cca_rx_model.sv
// receive-side stand-in: energy samples and command pulses
// assumes the bench calls its tasks; drives on rising edges only
`timescale 1ns/1ps
`default_nettype none
module cca_rx_model (
  input wire logic clk_sys,
  output logic [7:0] energySample,
  output logic rxOnCmd,
  output logic ackRequest,
  output logic addrMismatch
);
  initial
  begin
    energySample = 8'h00;
    rxOnCmd = 1'b0;
    ackRequest = 1'b0;
    addrMismatch = 1'b0;
  end
  task automatic level(input logic [7:0] v);
    @(posedge clk_sys);
    energySample <= v;
  endtask
  // one-cycle pulse: 0 receive-on, 1 ack, 2 mismatch
  task automatic pulse(input int which);
    @(posedge clk_sys);
    rxOnCmd <= (which == 0);
    ackRequest <= (which == 1);
    addrMismatch <= (which == 2);
    @(posedge clk_sys);
    rxOnCmd <= 1'b0;
    ackRequest <= 1'b0;
    addrMismatch <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- clear_channel_assessment_tb.sv
// self-checking bench for the assessment engine
// assumes 50 MHz clock; checker bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module clear_channel_assessment_tb;
  logic clk_sys;
  logic rst_n;
  logic [8:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [3:0] byteEn = 4'hf;
  logic [1:0] addrOfs = 2'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rxOnCmd;
  logic ackRequest;
  logic addrMismatch;
  logic [7:0] energySample;
  logic ackGo;
  logic assessIrq;
  logic assessBusy;
  int n_fail = 0;
  int total_checks = 0;
  int cyc;
  cca_engine #(.WIN_DEPTH(8)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rxOnCmd(rxOnCmd), .ackRequest(ackRequest), .addrMismatch(addrMismatch),
    .energySample(energySample), .ackGo(ackGo), .assessIrq(assessIrq),
    .assessBusy(assessBusy));
  cca_rx_model mdl_u (.clk_sys(clk_sys), .energySample(energySample),
    .rxOnCmd(rxOnCmd), .ackRequest(ackRequest), .addrMismatch(addrMismatch));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // compare, bus and wait helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // latency tolerance covers pipeline edges only, far below one conversion
  task automatic check_time(input int got, input int exp);
    total_checks++;
    if (got < exp - 8 || got > exp + 8)
    begin
      n_fail++;
      $display("[FAIL] %0t latency %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [6:0] idx,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    avs_address <= {idx, addrOfs};
    // upper lanes carry junk that the block must ignore
    avs_writedata <= {24'h5a5a5a, d};
    avs_byteenable <= byteEn;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [6:0] idx, input logic [7:0] exp,
    input string what);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, exp, what);
  endtask
  // which 0 waits for the interrupt, 1 for the ack release
  task automatic wait_ev(input int which, output int c);
    c = 0;
    do
    begin
      @(posedge clk_sys);
      c++;
    end while ((which == 0 ? assessIrq : ackGo) !== 1'b1 && c < 20000);
    if (c >= 20000)
    begin
      n_fail++;
      $display("[FAIL] %0t event timeout", $time);
    end
  endtask
  task automatic clear_irq();
    rd(7'h15, 8'h04, "result before clear");
    wr(7'h70, 8'h01);
    rd(7'h15, 8'h00, "result after clear");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(7'h15, 8'h00, "control at rest");
    rd(7'h40, 8'h00, "unmapped");
    wr(7'h13, 8'h40);
    rd(7'h13, 8'h40, "threshold");
    byteEn = 4'he;
    wr(7'h13, 8'h11);
    byteEn = 4'hf;
    addrOfs = 2'h3;
    wr(7'h13, 8'h22);
    rd(7'h13, 8'h00, "misaligned read");
    addrOfs = 2'h0;
    rd(7'h13, 8'h40, "lane and offset writes ignored");
    wr(7'h18, 8'hff);
    rd(7'h18, 8'h03, "hold high width");
    wr(7'h18, 8'h00);
    wr(7'h12, 8'hff);
    wr(7'h08, 8'h10);
    check({7'h00, assessBusy}, 8'h00, "busy at rest");
    $display("test reset done");
  endtask
  task automatic t_normal();
    mdl_u.level(8'h80);
    wr(7'h15, 8'h10);
    mdl_u.pulse(0);
    wait_ev(0, cyc);
    check_time(cyc, 3 * 800);
    rd(7'h70, 8'h01, "irq status");
    rd(7'h15, 8'h05, "busy result");
    wr(7'h70, 8'h01);
    rd(7'h15, 8'h00, "cleared");
    mdl_u.level(8'h10);
    wr(7'h17, 8'h02);
    wr(7'h15, 8'h10);
    mdl_u.pulse(0);
    wait_ev(0, cyc);
    check_time(cyc, (1 + 2 + 2) * 800);
    clear_irq();
    wr(7'h17, 8'h00);
    $display("test normal done");
  endtask
  task automatic t_strong();
    wr(7'h12, 8'h20);
    mdl_u.level(8'h30);
    wr(7'h15, 8'h10);
    mdl_u.pulse(0);
    repeat (4000) @(posedge clk_sys);
    check({7'h00, assessIrq}, 8'h00, "no idle under strong");
    rd(7'h15, 8'h13, "pending result");
    mdl_u.level(8'h10);
    wait_ev(0, cyc);
    check({7'h00, assessIrq}, 8'h01, "idle after strong left");
    clear_irq();
    wr(7'h12, 8'hff);
    $display("test strong done");
  endtask
  task automatic t_idle_mode();
    mdl_u.level(8'h80);
    wr(7'h15, 8'h18);
    mdl_u.pulse(0);
    repeat (4000) @(posedge clk_sys);
    check({7'h00, assessIrq}, 8'h00, "idle mode busy");
    rd(7'h15, 8'h19, "idle mode running");
    mdl_u.level(8'h10);
    wait_ev(0, cyc);
    clear_irq();
    $display("test idle mode done");
  endtask
  task automatic t_loop();
    mdl_u.level(8'h80);
    wr(7'h15, 8'h30);
    mdl_u.pulse(0);
    repeat (4000) @(posedge clk_sys);
    rd(7'h15, 8'h31, "loop busy");
    mdl_u.level(8'h10);
    repeat (1700) @(posedge clk_sys);
    rd(7'h15, 8'h30, "loop idle");
    check({7'h00, assessIrq}, 8'h00, "loop irq");
    wr(7'h15, 8'h70);
    repeat (4) @(posedge clk_sys);
    check({7'h00, assessBusy}, 8'h00, "loop stopped");
    rd(7'h15, 8'h00, "loop bits cleared");
    $display("test loop done");
  endtask
  task automatic t_triggers();
    wr(7'h55, 8'h10);
    wr(7'h15, 8'h80);
    mdl_u.pulse(1);
    wait_ev(1, cyc);
    check_time(cyc, 3 * 800);
    repeat (4) @(posedge clk_sys);
    wr(7'h70, 8'h01);
    wr(7'h08, 8'h00);
    wr(7'h60, 8'h01);
    wr(7'h45, 8'h01);
    mdl_u.pulse(2);
    wait_ev(0, cyc);
    check_time(cyc, 3 * 890);
    wr(7'h70, 8'h01);
    $display("test triggers done");
  endtask
  // code 7 must act as eight samples
  task automatic t_average();
    wr(7'h1b, 8'h07);
    mdl_u.level(8'h80);
    wr(7'h15, 8'h10);
    mdl_u.pulse(0);
    wait_ev(0, cyc);
    check_time(cyc, (8 + 2) * 890);
    rd(7'h16, 8'h80, "energy average");
    rd(7'h15, 8'h05, "averaged busy");
    wr(7'h70, 8'h01);
    wr(7'h1b, 8'h00);
    $display("test average done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    avs_address = 9'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_normal();
    t_strong();
    t_idle_mode();
    t_loop();
    t_triggers();
    t_average();
    summarize();
  end
  // runs take about 40k cycles; twice that means a hang
  initial
  begin
    #1600000;
    n_fail++;
    $display("[FAIL] %0t watchdog", $time);
    summarize();
  end
endmodule
bind cca_engine cca_engine_checker #(.WIN_DEPTH(WIN_DEPTH)) chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ackGo(ackGo),
  .assessIrq(assessIrq), .assessBusy(assessBusy));
`default_nettype wire
